// File: hw/fscg_pkg.sv
package fscg_pkg;

   // Clock
   localparam int CLK_MHZ = 100;

   // Pin timing in ns, rounded up to cycles
   localparam int T_ADDR_SETUP_NS   = 20;
   localparam int T_STROBE_NS       = 150;
   localparam int T_HOLD_NS         = 20;
   localparam int T_RESET_PULSE_NS  = 100;
   localparam int T_RESET_RECOV_NS  = 1000;

   localparam int SETUP_CYC_I = (T_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CYC_I = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC_I = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_PULSE_CYC_I = (T_RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_RECOV_CYC_I = (T_RESET_RECOV_NS * CLK_MHZ + 999) / 1000;

   localparam logic [7:0]  SETUP_CYC     = 8'(SETUP_CYC_I);
   localparam logic [7:0]  STROBE_CYC    = 8'(STROBE_CYC_I);
   localparam logic [7:0]  HOLD_CYC      = 8'(HOLD_CYC_I);
   localparam logic [7:0]  CAPT_CYC      = 8'h03;
   localparam logic [15:0] RST_PULSE_CYC = 16'(RST_PULSE_CYC_I);
   localparam logic [15:0] RST_RECOV_CYC = 16'(RST_RECOV_CYC_I);

   // Flash side
   localparam int          ADDR_W          = 24;
   localparam int          DQ_W            = 16;
   localparam logic [15:0] CMD_READ_ARRAY  = 16'h00FF;
   localparam int          XSR_BUF_FREE_BIT = 7;
   localparam int          SR_READY_BIT    = 7;

   // Register offsets
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_ADDR     = 12'h004;
   localparam logic [11:0] OFS_DATA     = 12'h008;
   localparam logic [11:0] OFS_CMD      = 12'h00C;
   localparam logic [11:0] OFS_STATUS   = 12'h010;
   localparam logic [11:0] OFS_INT_STAT = 12'h014;
   localparam logic [11:0] OFS_INT_MASK = 12'h018;
   localparam logic [11:0] OFS_RETRY    = 12'h01C;

   // Control fields
   localparam int CTRL_PROG_EN_BIT = 0;
   localparam int CTRL_POLL_BIT    = 1;
   localparam int CTRL_CE_ON_LSB   = 4;
   localparam int CTRL_CE_OFF_LSB  = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0601;
   localparam logic [15:0] RETRY_RESET = 16'h0040;

   // Status fields
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_ARRAY_BIT = 1;
   localparam int ST_PIN_BIT   = 2;
   localparam int ST_XSR_LSB   = 8;
   localparam int ST_RDATA_LSB = 16;

   // Interrupt bits
   localparam int IRQ_W         = 4;
   localparam int IRQ_DONE      = 0;
   localparam int IRQ_BUF_FREE  = 1;
   localparam int IRQ_BUF_TMO   = 2;
   localparam int IRQ_ABORTED   = 3;

   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_WRITE = 3'h1,
      OP_READ  = 3'h2,
      OP_SEQ2  = 3'h3,
      OP_BUFWR = 3'h4,
      OP_RESET = 3'h5,
      OP_ARRAY = 3'h6
   } fscg_op_e;

   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   data;
   } fscg_req_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   dq_out;
      logic              dq_oe;
      logic              we_n;
      logic              oe_n;
      logic [2:0]        chip_select;
   } fscg_pins_s;

endpackage

// File: hw/fscg_bus_cycle.sv
`timescale 1ns/10ps
module fscg_bus_cycle (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Request
   input  wire logic               start,
   input  fscg_pkg::fscg_req_s     req,
   input  wire logic [2:0]         ce_on,
   input  wire logic [2:0]         ce_off,
   output logic                    done_ff,
   output logic [15:0]             rdata_ff,
   // Flash pins
   output fscg_pkg::fscg_pins_s    pins_ff,
   input  wire logic [15:0]        dq_in
);

   typedef enum {S_IDLE, S_SETUP, S_STROBE, S_CAPT, S_HOLD} fscg_cyc_e;

   fscg_cyc_e   state_ff;
   logic [7:0]  cnt_ff;
   logic        wr_ff;
   logic [15:0] dq_s1_ff;
   logic [15:0] dq_s2_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_s1_ff <= 16'h0000;
         dq_s2_ff <= 16'h0000;
      end else begin
         dq_s1_ff <= dq_in;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= S_IDLE;
         cnt_ff   <= 8'h00;
         wr_ff    <= 1'b0;
         done_ff  <= 1'b0;
         rdata_ff <= 16'h0000;
         pins_ff  <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, we_n: 1'b1, oe_n: 1'b1,
                       chip_select: 3'b000};
      end else begin
         done_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               pins_ff.chip_select <= ce_off;
               if (start) begin
                  wr_ff               <= req.wr;
                  pins_ff.addr        <= req.addr;
                  pins_ff.dq_out      <= req.data;
                  pins_ff.dq_oe       <= req.wr;
                  pins_ff.chip_select <= ce_on;
                  cnt_ff              <= fscg_pkg::SETUP_CYC;
                  state_ff            <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_ff <= 8'h01) begin
                  // Strobe only with the enabling select combination in place
                  pins_ff.we_n <= !wr_ff;
                  pins_ff.oe_n <= wr_ff;
                  cnt_ff       <= fscg_pkg::STROBE_CYC;
                  state_ff     <= S_STROBE;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            S_STROBE: begin
               if (cnt_ff <= 8'h01) begin
                  pins_ff.we_n <= 1'b1;
                  cnt_ff       <= wr_ff ? fscg_pkg::HOLD_CYC : fscg_pkg::CAPT_CYC;
                  state_ff     <= wr_ff ? S_HOLD : S_CAPT;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            S_CAPT: begin
               // Output enable held through the synchroniser delay
               if (cnt_ff <= 8'h01) begin
                  rdata_ff     <= dq_s2_ff;
                  pins_ff.oe_n <= 1'b1;
                  cnt_ff       <= fscg_pkg::HOLD_CYC;
                  state_ff     <= S_HOLD;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            S_HOLD: begin
               if (cnt_ff <= 8'h01) begin
                  pins_ff.dq_oe       <= 1'b0;
                  pins_ff.chip_select <= ce_off;
                  done_ff             <= 1'b1;
                  state_ff            <= S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

endmodule

// File: hw/fscg_top.sv
`timescale 1ns/10ps
// Contract
// - Host loads buffer only after flag reads one
// - Host masks extended status low seven bits
// - Host reissues interrupted erase or lock operations
// - Host writes read-array before reading array again
// - Altering data takes setup plus confirm writes
module fscg_top (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata_ff,
   output logic                    pready_ff,
   output logic                    pslverr_ff,
   // Interrupt
   output logic                    irq_ff,
   // Flash pins
   output fscg_pkg::fscg_pins_s    flash_pins,
   input  wire logic [15:0]        dq_in,
   output logic                    reset_powerdown_n_ff,
   output logic                    program_enable_ff,
   input  wire logic               completion_pin
);

   typedef enum {T_IDLE, T_WAIT_SEQ, T_CONFIRM, T_WAIT_OP, T_POLL_CHK, T_FIN_OP,
                 T_BUF_CMD, T_BUF_RD, T_BUF_CHK, T_FIN, T_RST_LO, T_RST_REC} fscg_top_e;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a[1:0] == 2'b00) && (a <= fscg_pkg::OFS_RETRY);
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [31:0]              ctrl_ff;
   logic [23:0]              addr_ff;
   logic [31:0]              data_ff;
   logic [15:0]              retry_ff;
   logic [fscg_pkg::IRQ_W-1:0] int_stat_ff;
   logic [fscg_pkg::IRQ_W-1:0] int_mask_ff;
   logic [fscg_pkg::IRQ_W-1:0] ev_ff;
   logic                     cmd_go_ff;
   logic [2:0]               cmd_op_ff;
   fscg_top_e                state_ff;
   fscg_top_e                ret_ff;
   logic                     seq_start_ff;
   fscg_pkg::fscg_req_s      seq_req_ff;
   logic                     seq_done;
   logic [15:0]              seq_rdata;
   logic [15:0]              rdata_ff;
   logic [7:0]               xsr_ff;
   logic                     array_mode_ff;
   logic [15:0]              tmr_ff;
   logic [15:0]              polls_ff;
   logic                     pin_s1_ff;
   logic                     pin_s2_ff;
   logic                     apb_wr;
   logic                     busy;

   assign apb_wr = psel && penable && pwrite;
   assign busy   = (state_ff != T_IDLE);

   // Completion pin is asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_ff <= 1'b1;
         pin_s2_ff <= 1'b1;
      end else begin
         pin_s1_ff <= completion_pin;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // APB response, registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= 1'b1;
         if (psel && !penable) begin
            pslverr_ff <= !is_mapped(paddr);
            prdata_ff  <= 32'h0000_0000;
            case (paddr)
               fscg_pkg::OFS_CTRL:     prdata_ff <= ctrl_ff;
               fscg_pkg::OFS_ADDR:     prdata_ff <= {8'h00, addr_ff};
               fscg_pkg::OFS_DATA:     prdata_ff <= data_ff;
               fscg_pkg::OFS_STATUS: begin
                  prdata_ff[fscg_pkg::ST_BUSY_BIT]  <= busy;
                  prdata_ff[fscg_pkg::ST_ARRAY_BIT] <= array_mode_ff;
                  prdata_ff[fscg_pkg::ST_PIN_BIT]   <= pin_s2_ff;
                  prdata_ff[fscg_pkg::ST_XSR_LSB +: 8]   <= xsr_ff;
                  prdata_ff[fscg_pkg::ST_RDATA_LSB +: 16] <= rdata_ff;
               end
               fscg_pkg::OFS_INT_STAT: prdata_ff <= {28'h000_0000, int_stat_ff};
               fscg_pkg::OFS_INT_MASK: prdata_ff <= {28'h000_0000, int_mask_ff};
               fscg_pkg::OFS_RETRY:    prdata_ff <= {16'h0000, retry_ff};
               default:                prdata_ff <= 32'h0000_0000;
            endcase
         end else begin
            // Error flag stands only through the access phase
            pslverr_ff <= 1'b0;
         end
      end
   end

   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff     <= fscg_pkg::CTRL_RESET;
         addr_ff     <= 24'h00_0000;
         data_ff     <= 32'h0000_0000;
         retry_ff    <= fscg_pkg::RETRY_RESET;
         int_mask_ff <= 4'h0;
         cmd_go_ff   <= 1'b0;
         cmd_op_ff   <= 3'h0;
      end else begin
         cmd_go_ff <= 1'b0;
         if (apb_wr) begin
            if (hit(paddr, fscg_pkg::OFS_CTRL)) ctrl_ff <= pwdata & 32'h0000_0773;
            if (hit(paddr, fscg_pkg::OFS_ADDR)) addr_ff <= pwdata[23:0];
            if (hit(paddr, fscg_pkg::OFS_DATA)) data_ff <= pwdata;
            if (hit(paddr, fscg_pkg::OFS_RETRY)) retry_ff <= pwdata[15:0];
            if (hit(paddr, fscg_pkg::OFS_INT_MASK)) int_mask_ff <= pwdata[3:0];
            // Commands written while busy are dropped
            if (hit(paddr, fscg_pkg::OFS_CMD) && !busy) begin
               cmd_go_ff <= 1'b1;
               cmd_op_ff <= pwdata[2:0];
            end
         end
      end
   end

   // Sticky events, set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_ff <= 4'h0;
         irq_ff      <= 1'b0;
      end else begin
         if (apb_wr && hit(paddr, fscg_pkg::OFS_INT_STAT)) begin
            int_stat_ff <= (int_stat_ff & ~pwdata[3:0]) | ev_ff;
         end else begin
            int_stat_ff <= int_stat_ff | ev_ff;
         end
         irq_ff <= |(int_stat_ff & int_mask_ff);
      end
   end

   // Operation sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff             <= T_RST_REC;
         ret_ff               <= T_IDLE;
         seq_start_ff         <= 1'b0;
         seq_req_ff           <= '{wr: 1'b0, addr: '0, data: '0};
         rdata_ff             <= 16'h0000;
         xsr_ff               <= 8'h00;
         array_mode_ff        <= 1'b0;
         tmr_ff               <= fscg_pkg::RST_RECOV_CYC;
         polls_ff             <= 16'h0000;
         ev_ff                <= 4'h0;
         reset_powerdown_n_ff <= 1'b0;
         program_enable_ff    <= 1'b0;
      end else begin
         seq_start_ff      <= 1'b0;
         ev_ff             <= 4'h0;
         program_enable_ff <= ctrl_ff[fscg_pkg::CTRL_PROG_EN_BIT];
         case (state_ff)
            T_IDLE: begin
               if (cmd_go_ff) begin
                  seq_start_ff <= 1'b1;
                  seq_req_ff   <= '{wr: 1'b1, addr: addr_ff, data: data_ff[15:0]};
                  state_ff     <= T_WAIT_SEQ;
                  case (cmd_op_ff)
                     fscg_pkg::OP_WRITE: begin
                        array_mode_ff <= 1'b0;
                        ret_ff        <= T_FIN;
                     end
                     fscg_pkg::OP_READ: begin
                        seq_req_ff.wr <= 1'b0;
                        ret_ff        <= T_FIN;
                     end
                     fscg_pkg::OP_SEQ2: begin
                        array_mode_ff <= 1'b0;
                        ret_ff        <= T_CONFIRM;
                     end
                     fscg_pkg::OP_BUFWR: begin
                        array_mode_ff <= 1'b0;
                        polls_ff      <= 16'h0000;
                        ret_ff        <= T_BUF_RD;
                     end
                     fscg_pkg::OP_ARRAY: begin
                        seq_req_ff.data <= fscg_pkg::CMD_READ_ARRAY;
                        ret_ff          <= T_FIN_OP;
                     end
                     fscg_pkg::OP_RESET: begin
                        seq_start_ff <= 1'b0;
                        // Device mid-operation: it will abort, software must reissue
                        ev_ff[fscg_pkg::IRQ_ABORTED] <= !pin_s2_ff;
                        reset_powerdown_n_ff <= 1'b0;
                        tmr_ff               <= fscg_pkg::RST_PULSE_CYC;
                        state_ff             <= T_RST_LO;
                     end
                     default: begin
                        seq_start_ff <= 1'b0;
                        state_ff     <= T_IDLE;
                     end
                  endcase
               end
            end
            T_WAIT_SEQ: begin
               if (seq_done) begin
                  rdata_ff <= seq_rdata;
                  state_ff <= ret_ff;
               end
            end
            T_CONFIRM: begin
               seq_start_ff <= 1'b1;
               seq_req_ff   <= '{wr: 1'b1, addr: addr_ff, data: data_ff[31:16]};
               ret_ff       <= T_WAIT_OP;
               state_ff     <= T_WAIT_SEQ;
            end
            T_WAIT_OP: begin
               // Default pin mode: released pin marks completion
               if (ctrl_ff[fscg_pkg::CTRL_POLL_BIT]) begin
                  seq_start_ff <= 1'b1;
                  seq_req_ff   <= '{wr: 1'b0, addr: addr_ff, data: 16'h0000};
                  ret_ff       <= T_POLL_CHK;
                  state_ff     <= T_WAIT_SEQ;
               end else if (pin_s2_ff) begin
                  state_ff <= T_POLL_CHK;
                  rdata_ff[fscg_pkg::SR_READY_BIT] <= 1'b1;
               end
            end
            T_POLL_CHK: begin
               if (rdata_ff[fscg_pkg::SR_READY_BIT]) begin
                  // Back to array reads before software touches memory
                  seq_start_ff <= 1'b1;
                  seq_req_ff   <= '{wr: 1'b1, addr: addr_ff,
                                    data: fscg_pkg::CMD_READ_ARRAY};
                  ret_ff       <= T_FIN_OP;
                  state_ff     <= T_WAIT_SEQ;
               end else begin
                  state_ff <= T_WAIT_OP;
               end
            end
            T_FIN_OP: begin
               array_mode_ff            <= 1'b1;
               ev_ff[fscg_pkg::IRQ_DONE] <= 1'b1;
               state_ff                 <= T_IDLE;
            end
            T_BUF_CMD: begin
               seq_start_ff <= 1'b1;
               seq_req_ff   <= '{wr: 1'b1, addr: addr_ff, data: data_ff[15:0]};
               ret_ff       <= T_BUF_RD;
               state_ff     <= T_WAIT_SEQ;
            end
            T_BUF_RD: begin
               seq_start_ff <= 1'b1;
               seq_req_ff   <= '{wr: 1'b0, addr: addr_ff, data: 16'h0000};
               ret_ff       <= T_BUF_CHK;
               state_ff     <= T_WAIT_SEQ;
            end
            T_BUF_CHK: begin
               // Reserved low bits dropped so stale values never steer polling
               xsr_ff <= {rdata_ff[fscg_pkg::XSR_BUF_FREE_BIT], 7'h00};
               if (rdata_ff[fscg_pkg::XSR_BUF_FREE_BIT]) begin
                  ev_ff[fscg_pkg::IRQ_BUF_FREE] <= 1'b1;
                  state_ff                      <= T_IDLE;
               end else if (polls_ff >= retry_ff) begin
                  ev_ff[fscg_pkg::IRQ_BUF_TMO] <= 1'b1;
                  state_ff                     <= T_IDLE;
               end else begin
                  polls_ff <= polls_ff + 16'h0001;
                  state_ff <= T_BUF_CMD;
               end
            end
            T_FIN: begin
               ev_ff[fscg_pkg::IRQ_DONE] <= 1'b1;
               state_ff                 <= T_IDLE;
            end
            T_RST_LO: begin
               // No bus cycles are started while reset is held
               if (tmr_ff <= 16'h0001) begin
                  reset_powerdown_n_ff <= 1'b1;
                  tmr_ff               <= fscg_pkg::RST_RECOV_CYC;
                  state_ff             <= T_RST_REC;
               end else begin
                  tmr_ff <= tmr_ff - 16'h0001;
               end
            end
            T_RST_REC: begin
               reset_powerdown_n_ff <= 1'b1;
               if (tmr_ff <= 16'h0001) begin
                  // Device came out in array mode with its status cleared
                  array_mode_ff            <= 1'b1;
                  xsr_ff                   <= 8'h00;
                  ev_ff[fscg_pkg::IRQ_DONE] <= 1'b1;
                  state_ff                 <= T_IDLE;
               end else begin
                  tmr_ff <= tmr_ff - 16'h0001;
               end
            end
            default: state_ff <= T_IDLE;
         endcase
      end
   end

   fscg_bus_cycle u_cycle (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (seq_start_ff),
      .req      (seq_req_ff),
      .ce_on    (ctrl_ff[fscg_pkg::CTRL_CE_ON_LSB +: 3]),
      .ce_off   (ctrl_ff[fscg_pkg::CTRL_CE_OFF_LSB +: 3]),
      .done_ff  (seq_done),
      .rdata_ff (seq_rdata),
      .pins_ff  (flash_pins),
      .dq_in    (dq_in)
   );

endmodule

// File: verification/fscg_flash_model.sv
`timescale 1ns/10ps
module fscg_flash_model #(
   parameter int BUSY_NS   = 3000,
   parameter int BUF_POLLS = 3
) (
   // Host pins
   input  wire fscg_pkg::fscg_pins_s pins,
   input  wire logic                 reset_powerdown_n,
   input  wire logic                 program_enable,
   // Device outputs
   output logic [15:0]               dq_in,
   output wire                       completion_pin
);
   logic        busy = 1'b0;
   logic        armed = 1'b0;
   logic        xsr_mode = 1'b0;
   logic [7:0]  polls = 8'h00;
   logic [15:0] last = 16'h0000;
   wire         sel = pins.chip_select == 3'b000 && reset_powerdown_n;
   // Open drain: only ever pulls low
   assign completion_pin = busy ? 1'b0 : 1'bz;
   always @(negedge reset_powerdown_n) begin
      armed = 1'b0;
      xsr_mode = 1'b0;
   end
   always @(posedge busy) begin
      #(BUSY_NS);
      wait (reset_powerdown_n);
      busy = 1'b0;
   end
   // Commands latched only by host writes
   always @(posedge pins.we_n) if (sel) begin
      if (armed && program_enable) busy = 1'b1;
      armed = !armed && (pins.dq_out[7:0] == 8'h20 || pins.dq_out[7:0] == 8'h40);
      xsr_mode = pins.dq_out[7:0] == 8'hE8;
      if (!xsr_mode) polls = 8'h00;
   end
   always @(negedge pins.oe_n) if (sel && xsr_mode) polls = polls + 8'h01;
   always @(posedge pins.oe_n) last = dq_in;
   always @* begin
      if (sel && !pins.oe_n && xsr_mode)
         dq_in = {8'h00, polls >= BUF_POLLS, busy ? 7'bz : 7'h00};
      else if (sel && !pins.oe_n)
         dq_in = {8'h00, !busy, 7'h00};
      else
         dq_in = ~last;
   end
endmodule

// File: verification/fscg_top_props.sv
`timescale 1ns/10ps
module fscg_top_props (
   // Watched ports
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready_ff,
   input wire logic                 pslverr_ff,
   input wire logic                 irq_ff,
   input wire fscg_pkg::fscg_pins_s flash_pins,
   input wire logic                 reset_powerdown_n_ff
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_strobe_data: assert property (!flash_pins.we_n |-> flash_pins.dq_oe)
      else $error("write strobe without data");
   a_strobe_excl: assert property (!(!flash_pins.we_n && !flash_pins.oe_n))
      else $error("both strobes low");
   a_pwrdn_quiet: assert property (!reset_powerdown_n_ff |-> flash_pins.we_n)
      else $error("write strobe in power-down");
   a_pulse_len: assert property ($fell(reset_powerdown_n_ff) |-> (!reset_powerdown_n_ff)[*8])
      else $error("reset pulse too short");
   a_we_width: assert property ($fell(flash_pins.we_n) |-> (!flash_pins.we_n)[*8])
      else $error("write strobe too short");
   a_read_float: assert property (!flash_pins.oe_n |-> !flash_pins.dq_oe)
      else $error("bus driven during read");
   a_ready_access: assert property (psel && penable |-> pready_ff)
      else $error("no ready in access");
   a_err_access: assert property (pslverr_ff |-> psel && penable)
      else $error("error outside access");
   cover property ($fell(reset_powerdown_n_ff));
   cover property ($rose(irq_ff));
   cover property (pslverr_ff);
endmodule
bind fscg_top fscg_top_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff),
   .flash_pins(flash_pins), .reset_powerdown_n_ff(reset_powerdown_n_ff));

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, irq_ff, rpn, pen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_ff, rdata;
   logic [15:0] dq;
   tri1 sts;
   fscg_pkg::fscg_pins_s pins;
   int errors = 0;
   int n_checks = 0;
   int n_busy = 0;
   fscg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
      .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff), .flash_pins(pins),
      .dq_in(dq), .reset_powerdown_n_ff(rpn), .program_enable_ff(pen), .completion_pin(sts));
   fscg_flash_model flash_u (.pins(pins), .reset_powerdown_n(rpn), .program_enable(pen),
      .dq_in(dq), .completion_pin(sts));
   always @(negedge sts) n_busy++;
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready_ff !== 1'b1);
      rdata = pslverr_ff === 1'b1 ? 32'hFFFF_FFFF : prdata_ff;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdata & m, e);
   endtask
   task automatic run_op(input logic [31:0] d, input logic [31:0] op);
      apb(1'b1, fscg_pkg::OFS_DATA, d);
      apb(1'b1, fscg_pkg::OFS_CMD, op);
      do apb(1'b0, fscg_pkg::OFS_STATUS, 32'h0000_0000); while (rdata[0] !== 1'b0);
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (40000) @(posedge pclk);
      errors++;
      complete_run;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      run_op(32'h0000_0000, 32'h0000_0000);
      rdm(fscg_pkg::OFS_CTRL, 32'hFFFF_FFFF, fscg_pkg::CTRL_RESET);
      rdm(fscg_pkg::OFS_RETRY, 32'hFFFF_FFFF, 32'(fscg_pkg::RETRY_RESET));
      rdm(fscg_pkg::OFS_STATUS, 32'h0000_FF07, 32'h0000_0006);
      rdm(fscg_pkg::OFS_INT_STAT, 32'h0000_000F, 32'h0000_0001);
      rdm(12'h020, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      apb(1'b1, fscg_pkg::OFS_INT_MASK, 32'h0000_0001);
      @(posedge pclk);
      chk(32'(irq_ff), 32'h0000_0001);
      apb(1'b1, fscg_pkg::OFS_INT_STAT, 32'h0000_0001);
      @(posedge pclk);
      chk(32'(irq_ff), 32'h0000_0000);
      // Supply enabled, then held off: only the first alters
      for (int p = 1; p >= 0; p--) begin
         apb(1'b1, fscg_pkg::OFS_CTRL, 32'h0000_0600 | 32'(p));
         run_op(32'h00D0_0040, 32'h0000_0003);
         chk(32'(n_busy), 32'h0000_0001);
         rdm(fscg_pkg::OFS_STATUS, 32'h0000_0007, 32'h0000_0006);
      end
      run_op(32'h0000_00E8, 32'h0000_0004);
      rdm(fscg_pkg::OFS_STATUS, 32'h0000_FF00, 32'h0000_8000);
      rdm(fscg_pkg::OFS_INT_STAT, 32'h0000_0006, 32'h0000_0002);
      run_op(32'h0000_0000, 32'h0000_0006);
      apb(1'b1, fscg_pkg::OFS_RETRY, 32'h0000_0001);
      run_op(32'h0000_00E8, 32'h0000_0004);
      rdm(fscg_pkg::OFS_INT_STAT, 32'h0000_0004, 32'h0000_0004);
      run_op(32'h0000_0000, 32'h0000_0005);
      rdm(fscg_pkg::OFS_INT_STAT, 32'h0000_0008, 32'h0000_0000);
      rdm(fscg_pkg::OFS_STATUS, 32'h0000_0007, 32'h0000_0006);
      // Poll mode: completion read from status bit 7 instead of the pin
      apb(1'b1, fscg_pkg::OFS_CTRL, 32'h0000_0603);
      run_op(32'h00D0_0040, 32'h0000_0003);
      chk(32'(n_busy), 32'h0000_0002);
      rdm(fscg_pkg::OFS_STATUS, 32'h0080_0007, 32'h0080_0006);
      // Raw setup and confirm leave the device busy, then reset flags it aborted while the pin stays low
      run_op(32'h0000_0040, 32'h0000_0001);
      run_op(32'h0000_00D0, 32'h0000_0001);
      run_op(32'h0000_0000, 32'h0000_0005);
      rdm(fscg_pkg::OFS_INT_STAT, 32'h0000_0008, 32'h0000_0008);
      rdm(fscg_pkg::OFS_STATUS, 32'h0000_0007, 32'h0000_0002);
      complete_run;
   end
endmodule
